// >>> common/swl_pkg.sv
// Package of register map, field positions and counts for the serial wakeup/loop control block
package swl_pkg;
	// Register byte offsets on the register bus
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFS_STAT_ONE = 8'h08;
	localparam logic [7:0] OFS_STAT_TWO = 8'h0C;
	localparam logic [7:0] OFS_DATA_LOW = 8'h10;
	// serial_control_one fields
	localparam int C1_LOOP = 7;
	localparam int C1_RECEIVER_SOURCE_SELECT = 5;
	localparam int C1_LONG = 4;
	localparam int C1_WAKE = 3;
	localparam int C1_ILT = 2;
	// serial_control_two fields
	localparam int C2_TIE = 7;
	localparam int C2_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
	localparam int C2_RIE = 5;
	localparam int C2_LINE_IDLE_IRQ_ENABLE = 4;
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	localparam int C2_RWU = 1;
	// serial_status_one fields
	localparam int S1_TRANSMIT_EMPTY_FLAG = 7;
	localparam int S1_TC = 6;
	localparam int S1_RECEIVE_FULL_FLAG = 5;
	localparam int S1_IDLE = 4;
	localparam int S1_OR = 3;
	// serial_status_two fields
	localparam int S2_TRANSMIT_PIN_DIRECTION = 1;
	// Reset values
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [8:0] DATA_RST = 9'h000;
	// Ones needed for an idle character, short and long frames
	localparam logic [3:0] IDLE_SHORT = 4'hA;
	localparam logic [3:0] IDLE_LONG = 4'hB;
	// Data width and msb positions
	localparam int DW = 9;
	localparam int MSB_SHORT = 7;
	localparam int MSB_LONG = 8;
endpackage

// >>> rtl/swl_core.sv
// Serial interface control: standby wakeup, loop routing, status flags, interrupt, APB registers
`timescale 1ns/10ps
`default_nettype none
module swl_core (
	input wire logic CLK,
	input wire logic RESET_N,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Pins
	input wire logic RXD_PIN,
	input wire logic TXD_PIN_IN,
	output logic TXD_PIN_OUT,
	output logic TXD_PIN_OE_N,
	// Transmitter side
	input wire logic TX_SERIAL,
	input wire logic TX_LOAD,
	input wire logic TX_BUSY,
	input wire logic TX_QUEUED,
	output logic [8:0] TX_DATA,
	output logic TX_PENDING,
	output logic TX_ENABLE,
	// Receiver recovery side
	output logic RX_LINE,
	output logic RX_ENABLE,
	output logic RX_LONG,
	input wire logic RX_BIT_TICK,
	input wire logic RX_BIT,
	input wire logic RX_START,
	input wire logic RX_MSB_TICK,
	input wire logic RX_DONE,
	input wire logic [8:0] RX_DATA,
	// Interrupt
	output logic IRQ
);
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic transmit_pin_direction_q;
	logic [8:0] rx_data_q;
	logic [8:0] tx_data_q;
	logic transmit_empty_flag_q, tc_q, receive_full_flag_q, idle_q, or_q;
	logic [4:0] seen_q;
	logic rwu_q;
	logic idle_arm_q;
	logic [3:0] ones_q;
	logic in_frame_q;
	logic [1:0] rxd_sync_q, txd_sync_q;
	logic rx_line_q, txd_out_q, txd_oe_n_q, irq_q;
	logic [31:0] prdata_q;
	logic setup, acc, wr, rd;
	logic hit_c1, hit_c2, hit_s1, hit_s2, hit_dl, hit_any;
	logic rd_s1, rd_dl, wr_dl;
	logic internal_loop_select, receiver_source_select, wake, idle_count_start_select, long_frame, te, re;
	logic [3:0] idle_target;
	logic idle_level, idle_event;
	logic frame_ok, msb_one;
	logic rx_in;

	// Address match of one register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Field views of control registers
	assign internal_loop_select = ctrl1_q[swl_pkg::C1_LOOP];
	assign receiver_source_select = ctrl1_q[swl_pkg::C1_RECEIVER_SOURCE_SELECT];
	assign wake = ctrl1_q[swl_pkg::C1_WAKE];
	assign idle_count_start_select = ctrl1_q[swl_pkg::C1_ILT];
	assign long_frame = ctrl1_q[swl_pkg::C1_LONG];
	assign te = ctrl2_q[swl_pkg::C2_TE];
	assign re = ctrl2_q[swl_pkg::C2_RE];

	// Bus phase decode
	assign setup = PSEL & ~PENABLE;
	assign acc = PSEL & PENABLE;
	assign wr = acc & PWRITE;
	assign rd = acc & ~PWRITE;
	always_comb begin
		hit_c1 = 1'b0;
		hit_c2 = 1'b0;
		hit_s1 = 1'b0;
		hit_s2 = 1'b0;
		hit_dl = 1'b0;
		if (hit(PADDR, swl_pkg::OFS_CTRL_ONE)) begin
			hit_c1 = 1'b1;
		end else if (hit(PADDR, swl_pkg::OFS_CTRL_TWO)) begin
			hit_c2 = 1'b1;
		end else if (hit(PADDR, swl_pkg::OFS_STAT_ONE)) begin
			hit_s1 = 1'b1;
		end else if (hit(PADDR, swl_pkg::OFS_STAT_TWO)) begin
			hit_s2 = 1'b1;
		end else if (hit(PADDR, swl_pkg::OFS_DATA_LOW)) begin
			hit_dl = 1'b1;
		end
	end
	assign hit_any = hit_c1 | hit_c2 | hit_s1 | hit_s2 | hit_dl;
	assign rd_s1 = rd & hit_s1;
	assign rd_dl = rd & hit_dl;
	assign wr_dl = wr & hit_dl;

	// Zero wait states; unmapped access answers with an error
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~hit_any;
	assign PRDATA = prdata_q;

	// Read data captured in the setup cycle
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup & ~PWRITE) begin
			prdata_q <= 32'h0000_0000;
			if (hit_c1) begin
				prdata_q[7:0] <= ctrl1_q;
			end else if (hit_c2) begin
				prdata_q[7:0] <= {ctrl2_q[7:2], rwu_q, ctrl2_q[0]};
			end else if (hit_s1) begin
				prdata_q[swl_pkg::S1_TRANSMIT_EMPTY_FLAG] <= transmit_empty_flag_q;
				prdata_q[swl_pkg::S1_TC] <= tc_q;
				prdata_q[swl_pkg::S1_RECEIVE_FULL_FLAG] <= receive_full_flag_q;
				prdata_q[swl_pkg::S1_IDLE] <= idle_q;
				prdata_q[swl_pkg::S1_OR] <= or_q;
			end else if (hit_s2) begin
				prdata_q[swl_pkg::S2_TRANSMIT_PIN_DIRECTION] <= transmit_pin_direction_q;
			end else if (hit_dl) begin
				prdata_q[8:0] <= rx_data_q;
			end
		end
	end

	// Control registers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl1_q <= swl_pkg::CTRL_ONE_RST;
			ctrl2_q <= swl_pkg::CTRL_TWO_RST;
			transmit_pin_direction_q <= 1'b0;
		end else if (wr) begin
			if (hit_c1) begin
				ctrl1_q <= PWDATA[7:0];
			end
			if (hit_c2) begin
				ctrl2_q <= PWDATA[7:0];
			end
			if (hit_s2) begin
				transmit_pin_direction_q <= PWDATA[swl_pkg::S2_TRANSMIT_PIN_DIRECTION];
			end
		end
	end

	// Transmit data holding register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_data_q <= swl_pkg::DATA_RST;
		end else if (wr_dl) begin
			tx_data_q <= PWDATA[8:0];
		end
	end

	// Pin synchronisers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rxd_sync_q <= 2'h3;
			txd_sync_q <= 2'h3;
		end else begin
			rxd_sync_q <= {rxd_sync_q[0], RXD_PIN};
			txd_sync_q <= {txd_sync_q[0], TXD_PIN_IN};
		end
	end

	// Receiver source routing; in loop mode idles high unless both ends are enabled
	always_comb begin
		rx_in = rxd_sync_q[1];
		if (internal_loop_select) begin
			if (!(te & re)) begin
				rx_in = 1'b1;
			end else if (receiver_source_select) begin
				rx_in = transmit_pin_direction_q ? txd_out_q : txd_sync_q[1];
			end else begin
				rx_in = txd_out_q;
			end
		end
	end

	// Receiver line and transmit pin drive
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_line_q <= 1'b1;
			txd_out_q <= 1'b1;
			txd_oe_n_q <= 1'b0;
		end else begin
			rx_line_q <= rx_in;
			txd_out_q <= (te & ~tc_q) ? TX_SERIAL : 1'b1;
			txd_oe_n_q <= (internal_loop_select & receiver_source_select) ? ~transmit_pin_direction_q : 1'b0;
		end
	end

	// Frame window for idle counting after the stop bit
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			in_frame_q <= 1'b0;
		end else if (RX_START) begin
			in_frame_q <= 1'b1;
		end else if (RX_DONE) begin
			in_frame_q <= 1'b0;
		end
	end

	// Consecutive ones counter, saturates at the idle length
	assign idle_target = long_frame ? swl_pkg::IDLE_LONG : swl_pkg::IDLE_SHORT;
	assign idle_level = ones_q >= idle_target; // Holds even if the frame length shrinks mid-idle
	assign idle_event = RX_BIT_TICK & RX_BIT & (ones_q == idle_target - 4'h1);
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ones_q <= 4'h0;
		end else if (!re) begin
			ones_q <= 4'h0;
		end else if (idle_count_start_select & (in_frame_q | RX_START)) begin
			ones_q <= 4'h0;
		end else if (RX_BIT_TICK) begin
			if (!RX_BIT) begin
				ones_q <= 4'h0;
			end else if (!idle_level) begin
				ones_q <= ones_q + 4'h1;
			end
		end
	end

	// Standby request: set by software, cleared by the selected wakeup
	assign msb_one = RX_MSB_TICK & RX_BIT;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rwu_q <= 1'b0;
		end else if (wr & hit_c2) begin
			rwu_q <= PWDATA[swl_pkg::C2_RWU];
		end else if (rwu_q & re) begin
			if (!wake & idle_level) begin
				rwu_q <= 1'b0;
			end else if (wake & msb_one) begin
				rwu_q <= 1'b0;
			end
		end
	end

	// Receive data register, loaded even in standby
	assign frame_ok = RX_DONE & re;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_data_q <= swl_pkg::DATA_RST;
		end else if (frame_ok & (rwu_q | ~receive_full_flag_q)) begin
			rx_data_q <= RX_DATA;
		end
	end

	// Flags the last status read returned; only those may be cleared next
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			seen_q <= 5'h00;
		end else if (rd_s1) begin
			seen_q <= {prdata_q[swl_pkg::S1_TRANSMIT_EMPTY_FLAG], prdata_q[swl_pkg::S1_TC],
				prdata_q[swl_pkg::S1_RECEIVE_FULL_FLAG], prdata_q[swl_pkg::S1_IDLE], prdata_q[swl_pkg::S1_OR]};
		end else if (rd_dl | wr_dl) begin
			seen_q <= 5'h00;
		end
	end

	// Transmit-empty flag
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			transmit_empty_flag_q <= 1'b1;
		end else if (TX_LOAD) begin
			transmit_empty_flag_q <= 1'b1;
		end else if (wr_dl & seen_q[4]) begin
			transmit_empty_flag_q <= 1'b0;
		end
	end

	// Transmit-complete flag
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tc_q <= 1'b1;
		end else if (transmit_empty_flag_q & ~(wr_dl & seen_q[4]) & ~TX_BUSY & ~TX_LOAD) begin
			tc_q <= 1'b1;
		end else if (TX_QUEUED | (wr_dl & seen_q[3])) begin
			tc_q <= 1'b0;
		end
	end

	// Receive-full and overrun flags
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			receive_full_flag_q <= 1'b0;
			or_q <= 1'b0;
		end else begin
			if (frame_ok & ~rwu_q & ~receive_full_flag_q) begin
				receive_full_flag_q <= 1'b1;
			end else if (rd_dl & seen_q[2]) begin
				receive_full_flag_q <= 1'b0;
			end
			if (frame_ok & ~rwu_q & receive_full_flag_q) begin
				or_q <= 1'b1;
			end else if (rd_dl & seen_q[0]) begin
				or_q <= 1'b0;
			end
		end
	end

	// Line-idle flag and its rearm after a valid frame
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			idle_q <= 1'b0;
			idle_arm_q <= 1'b1;
		end else begin
			if (idle_event & idle_arm_q & ~rwu_q & re) begin
				idle_q <= 1'b1;
			end else if (rd_dl & seen_q[1]) begin
				idle_q <= 1'b0;
			end
			if (frame_ok & ~rwu_q & ~receive_full_flag_q) begin
				idle_arm_q <= 1'b1;
			end else if (idle_event & idle_arm_q & ~rwu_q & re) begin
				idle_arm_q <= 1'b0;
			end
		end
	end

	// Merged interrupt, receiver terms masked in standby; no clock gating so it works in wait
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (transmit_empty_flag_q & ctrl2_q[swl_pkg::C2_TIE])
				| (tc_q & ctrl2_q[swl_pkg::C2_TRANSMIT_COMPLETE_IRQ_ENABLE])
				| (~rwu_q & (receive_full_flag_q | or_q) & ctrl2_q[swl_pkg::C2_RIE])
				| (~rwu_q & idle_q & ctrl2_q[swl_pkg::C2_LINE_IDLE_IRQ_ENABLE]);
		end
	end

	// Outputs
	assign IRQ = irq_q;
	assign TXD_PIN_OUT = txd_out_q;
	assign TXD_PIN_OE_N = txd_oe_n_q;
	assign RX_LINE = rx_line_q;
	assign TX_DATA = tx_data_q;
	assign TX_PENDING = ~transmit_empty_flag_q;
	assign TX_ENABLE = te;
	assign RX_ENABLE = re;
	assign RX_LONG = long_frame;
endmodule
`default_nettype wire

// >>> sim/swl_core_chk.sv
// Port checker of the serial control block: bus refusal, transmit and enable fields
`timescale 1ns/10ps
`default_nettype none
module swl_core_chk (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PSLVERR,
	input wire logic TX_LOAD,
	input wire logic TX_PENDING,
	input wire logic TX_ENABLE,
	input wire logic RX_ENABLE,
	input wire logic RX_LONG,
	input wire logic [8:0] TX_DATA,
	input wire logic TXD_PIN_OUT
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	// Access phase marker
	wire logic acc = PSEL && PENABLE;
	bad_refused_a: assert property (acc && PADDR > 8'h10 |-> PSLVERR)
		else $error("unmapped access not refused");
	err_phase_a: assert property (PSLVERR |-> acc)
		else $error("error outside access phase");
	bad_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR > 8'h10 |=> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	empty_set_a: assert property (TX_LOAD |=> !TX_PENDING)
		else $error("transmit empty not set on load");
	pin_idle_a: assert property (!TX_ENABLE [*2] |-> TXD_PIN_OUT)
		else $error("transmit pin not idle high");
	tx_data_a: assert property (acc && PWRITE && PADDR == 8'h10 |=> TX_DATA == $past(PWDATA[8:0]))
		else $error("transmit data not held");
	enable_bits_a: assert property (acc && PWRITE && PADDR == 8'h04 |=>
		TX_ENABLE == $past(PWDATA[3]) && RX_ENABLE == $past(PWDATA[2]))
		else $error("enable bits wrong");
	long_sel_a: assert property (acc && PWRITE && PADDR == 8'h00 |=> RX_LONG == $past(PWDATA[4]))
		else $error("long frame bit wrong");
endmodule
bind swl_core swl_core_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
	.TX_LOAD(TX_LOAD), .TX_PENDING(TX_PENDING), .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE),
	.RX_LONG(RX_LONG), .TX_DATA(TX_DATA), .TXD_PIN_OUT(TXD_PIN_OUT));
`default_nettype wire

// >>> sim/swl_far_end.sv
// Behavioural far-end sender with the recovered bit strobes it causes
`timescale 1ns/10ps
`default_nettype none
module swl_far_end (
	input wire logic clk,
	input wire logic go,
	input wire logic with_frame,
	input wire logic [8:0] word,
	input wire logic [3:0] gap,
	input wire logic long_frame,
	output logic busy,
	output logic line,
	output logic start,
	output logic tick,
	output logic bit_v,
	output logic msb_tick,
	output logic done,
	output logic [8:0] data
);
	int n;
	// Idle line is pulled high
	initial begin
		{busy, start, tick, bit_v, msb_tick, done} = 6'h0;
		line = 1'h1;
		data = 9'h000;
	end
	// One bit every two clocks; data and bit value scramble between strobes
	task automatic bit_out(input logic b, input logic msb, input logic last);
		line <= b;
		tick <= 1'h1;
		bit_v <= b;
		msb_tick <= msb;
		done <= last;
		data <= last ? word : ~word;
		@(posedge clk);
		{tick, msb_tick, done} <= 3'h0;
		bit_v <= ~b;
		data <= ~word;
		@(posedge clk);
	endtask
	// Frame, then a run of idle ones
	always @(posedge clk) begin
		if (go) begin
			busy <= 1'h1;
			if (with_frame) begin
				line <= 1'h0;
				start <= 1'h1;
				@(posedge clk);
				start <= 1'h0;
				@(posedge clk);
				n = long_frame ? 9 : 8;
				for (int i = 0; i < n; i++) bit_out(word[i], i == n - 1, 1'h0);
				bit_out(1'h1, 1'h0, 1'h1);
			end
			repeat (gap) bit_out(1'h1, 1'h0, 1'h0);
			busy <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// >>> sim/swl_core_tb.sv
// Self-checking bench: registers, reception, wakeup, routing and transmit flags
`timescale 1ns/10ps
`default_nettype none
module swl_core_tb;
	logic CLK = 1'h0;
	logic RESET_N = 1'h0;
	logic PSEL = 1'h0;
	logic PENABLE = 1'h0;
	logic PWRITE = 1'h0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic TX_SERIAL = 1'h1;
	logic TX_LOAD = 1'h0;
	logic TX_BUSY = 1'h0;
	logic TX_QUEUED = 1'h0;
	logic go = 1'h0;
	logic wf = 1'h1;
	logic [8:0] word = 9'h000;
	logic [3:0] gap = 4'h0;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	wire logic [31:0] PRDATA;
	wire logic [8:0] TX_DATA, rx_data;
	wire logic PREADY, PSLVERR, TXD_PIN_OUT, TXD_PIN_OE_N, TX_PENDING, TX_ENABLE, RX_LINE;
	wire logic RX_ENABLE, RX_LONG, IRQ, busy, line, start, tick, bit_v, msb, done;
	// Transmit pin level: pulled high when released
	wire logic txd_wire = TXD_PIN_OE_N ? 1'h1 : TXD_PIN_OUT;
	swl_core dut (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .RXD_PIN(line), .TXD_PIN_IN(txd_wire), .TXD_PIN_OUT(TXD_PIN_OUT),
		.TXD_PIN_OE_N(TXD_PIN_OE_N), .TX_SERIAL(TX_SERIAL), .TX_LOAD(TX_LOAD),
		.TX_BUSY(TX_BUSY), .TX_QUEUED(TX_QUEUED), .TX_DATA(TX_DATA), .TX_PENDING(TX_PENDING),
		.TX_ENABLE(TX_ENABLE), .RX_LINE(RX_LINE), .RX_ENABLE(RX_ENABLE), .RX_LONG(RX_LONG),
		.RX_BIT_TICK(tick), .RX_BIT(bit_v), .RX_START(start), .RX_MSB_TICK(msb),
		.RX_DONE(done), .RX_DATA(rx_data), .IRQ(IRQ));
	swl_far_end far (.clk(CLK), .go(go), .with_frame(wf), .word(word), .gap(gap),
		.long_frame(RX_LONG), .busy(busy), .line(line), .start(start), .tick(tick),
		.bit_v(bit_v), .msb_tick(msb), .done(done), .data(rx_data));
	// 200 MHz clock and cycle ceiling
	always #2.5 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			wrap_up;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'h1;
		do @(posedge CLK); while (PREADY !== 1'h1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CLK);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic send(input logic f, input logic [8:0] w, input logic [3:0] g);
		wf <= f;
		word <= w;
		gap <= g;
		go <= 1'h1;
		@(posedge CLK);
		go <= 1'h0;
		@(posedge CLK);
		while (busy) @(posedge CLK);
		repeat (4) @(posedge CLK);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge CLK);
		RESET_N <= 1'h1;
		@(posedge CLK);
		rdc(8'h08, 32'hC0);
		apb(1'h1, 8'h00, 32'hFF);
		rdc(8'h00, 32'hFF);
		rdc(8'h14, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h04, 32'h2C);
		$display("test registers end");
		send(1'h1, 9'h05A, 4'h0);
		rdc(8'h08, 32'hE0);
		rdc(8'h10, 32'h5A);
		send(1'h1, 9'h011, 4'h0);
		send(1'h1, 9'h022, 4'h0);
		rdc(8'h08, 32'hE8);
		chk(32'(IRQ), 32'h1);
		rdc(8'h10, 32'h11);
		rdc(8'h08, 32'hC0);
		chk(32'(IRQ), 32'h0);
		$display("test receive end");
		apb(1'h1, 8'h04, 32'h1C);
		send(1'h1, 9'h000, 4'h8);
		rdc(8'h08, 32'hE0);
		send(1'h0, 9'h000, 4'h1);
		rdc(8'h08, 32'hF0);
		chk(32'(IRQ), 32'h1);
		rdc(8'h10, 32'h0);
		apb(1'h1, 8'h04, 32'h18);
		apb(1'h1, 8'h04, 32'h1C);
		send(1'h0, 9'h000, 4'hB);
		rdc(8'h08, 32'hC0);
		$display("test idle end");
		apb(1'h1, 8'h00, 32'h08);
		apb(1'h1, 8'h04, 32'h2E);
		send(1'h1, 9'h033, 4'h0);
		rdc(8'h08, 32'hC0);
		chk(32'(IRQ), 32'h0);
		rdc(8'h04, 32'h2E);
		rdc(8'h10, 32'h33);
		send(1'h1, 9'h0A5, 4'h0);
		rdc(8'h04, 32'h2C);
		rdc(8'h08, 32'hE0);
		rdc(8'h10, 32'hA5);
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h04, 32'h1E);
		send(1'h0, 9'h000, 4'h7);
		rdc(8'h04, 32'h1E);
		send(1'h0, 9'h000, 4'h1);
		rdc(8'h04, 32'h1C);
		rdc(8'h08, 32'hC0);
		$display("test wakeup end");
		apb(1'h1, 8'h00, 32'h14);
		apb(1'h1, 8'h04, 32'h1C);
		send(1'h1, 9'h1FF, 4'hA);
		rdc(8'h08, 32'hE0);
		send(1'h0, 9'h000, 4'h1);
		rdc(8'h08, 32'hF0);
		rdc(8'h10, 32'h1FF);
		$display("test long frame end");
		apb(1'h1, 8'h00, 32'h80);
		TX_BUSY <= 1'h1;
		TX_QUEUED <= 1'h1;
		TX_SERIAL <= 1'h0;
		@(posedge CLK);
		TX_QUEUED <= 1'h0;
		repeat (6) @(posedge CLK);
		chk(32'(RX_LINE), 32'h0);
		rdc(8'h08, 32'h80);
		apb(1'h1, 8'h10, 32'h1AB);
		chk(32'(TX_DATA), 32'h1AB);
		rdc(8'h08, 32'h00);
		TX_LOAD <= 1'h1;
		@(posedge CLK);
		TX_LOAD <= 1'h0;
		rdc(8'h08, 32'h80);
		TX_BUSY <= 1'h0;
		@(posedge CLK);
		rdc(8'h08, 32'hC0);
		chk(32'(TXD_PIN_OUT), 32'h1);
		apb(1'h1, 8'h00, 32'hA0);
		apb(1'h1, 8'h0C, 32'h2);
		repeat (2) @(posedge CLK);
		chk(32'(TXD_PIN_OE_N), 32'h0);
		TX_BUSY <= 1'h1;
		TX_QUEUED <= 1'h1;
		@(posedge CLK);
		TX_QUEUED <= 1'h0;
		repeat (6) @(posedge CLK);
		chk(32'(RX_LINE), 32'h0);
		apb(1'h1, 8'h0C, 32'h0);
		repeat (2) @(posedge CLK);
		chk(32'(TXD_PIN_OE_N), 32'h1);
		repeat (4) @(posedge CLK);
		chk(32'(RX_LINE), 32'h1);
		apb(1'h1, 8'h04, 32'h40);
		@(posedge CLK);
		chk(32'(IRQ), 32'h0);
		TX_BUSY <= 1'h0;
		repeat (3) @(posedge CLK);
		chk(32'(IRQ), 32'h1);
		apb(1'h1, 8'h04, 32'h80);
		@(posedge CLK);
		chk(32'(IRQ), 32'h1);
		rdc(8'h08, 32'hC0);
		apb(1'h1, 8'h10, 32'h55);
		rdc(8'h08, 32'h00);
		$display("test transmit end");
		wrap_up;
	end
endmodule
`default_nettype wire
